// ===== common/hmch_pkg.sv
`default_nettype none
package hmch_pkg;
  // register byte addresses on apb
  localparam logic [11:0] ADDR_DATA = 12'h000;
  localparam logic [11:0] ADDR_FEATURE = 12'h004;
  localparam logic [11:0] ADDR_SECCNT = 12'h008;
  localparam logic [11:0] ADDR_SECNUM = 12'h00c;
  localparam logic [11:0] ADDR_SIGLO = 12'h010;
  localparam logic [11:0] ADDR_SIGHI = 12'h014;
  localparam logic [11:0] ADDR_DRVSEL = 12'h018;
  localparam logic [11:0] ADDR_OPCODE = 12'h01c;
  localparam logic [11:0] ADDR_CTRL = 12'h020;
  localparam logic [11:0] ADDR_STATE = 12'h024;
  // command encodings
  localparam logic [7:0] OPC_HEALTH = 8'hb0;
  localparam logic [7:0] FEAT_AUTOSAVE = 8'hd2;
  localparam logic [7:0] FEAT_ENABLE = 8'hd8;
  localparam logic [7:0] FEAT_OFFLINE = 8'hd4;
  localparam logic [7:0] SIG_LO_KEY = 8'h4f;
  localparam logic [7:0] SIG_HI_KEY = 8'hc2;
  localparam logic [7:0] SIG_LO_FAIL = 8'hf4;
  localparam logic [7:0] SIG_HI_FAIL = 8'h2c;
  localparam logic [7:0] AUTOSAVE_OFF = 8'h00;
  localparam logic [7:0] AUTOSAVE_ON = 8'hf1;
  // off-line subcommands
  localparam logic [7:0] SUB_COLLECT = 8'h00;
  localparam logic [7:0] SUB_SHORT_OFF = 8'h01;
  localparam logic [7:0] SUB_EXT_OFF = 8'h02;
  localparam logic [7:0] SUB_ABORT_OFF = 8'h7f;
  localparam logic [7:0] SUB_SHORT_CAP = 8'h81;
  localparam logic [7:0] SUB_EXT_CAP = 8'h82;
  // field positions
  localparam int BIT_BUSY = 7;
  localparam int BIT_DRIVE_READY_FLAG = 6;
  localparam int BIT_DF = 5;
  localparam int BIT_DRQ = 3;
  localparam int BIT_ERR = 0;
  localparam int BIT_COMMAND_ABORTED_BIT = 2;
  localparam int BIT_DEVSEL = 4;
  localparam int CTRL_FAULT = 0;
  localparam int CTRL_TEST_FAIL = 1;
  localparam int CTRL_SUPPORT_AS = 2;
  // nv store slots
  localparam logic [1:0] NV_MON = 2'd0;
  localparam logic [1:0] NV_AS = 2'd1;
  // reset values
  localparam logic [7:0] RST_STATUS = 8'h40;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int RESP_LIMIT_MS = 2000;
  localparam int RESP_CYC = RESP_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int CAPTIVE_CYC = 16;
  localparam int ROUTINE_CYC = 64;
  typedef enum logic [1:0] {HMCH_IDLE, HMCH_EXEC, HMCH_CAPTIVE}
    hmch_state_t;
endpackage
`default_nettype wire

// ===== hw/hmch_nvstore.sv
`default_nettype none
// nonvolatile-backed settings: holds across presetn, loaded once
module hmch_nvstore
  import hmch_pkg::*;
(
  input wire logic pclk,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem_ff [4];
  // no reset: contents model flash and survive power cycles
  always_ff @(posedge pclk) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
    rdata <= mem_ff[raddr];
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      mem_ff[i] = 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== hw/hmch_timer.sv
`default_nettype none
module hmch_timer
  import hmch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [7:0] len,
  input wire logic stop,
  output logic busy,
  output logic done
);
  logic [7:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (stop) begin
        cnt_ff <= 8'h00;
      end else if (start) begin
        cnt_ff <= len;
      end else if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
        done <= (cnt_ff == 8'h01);
      end
    end
  end
  assign busy = (cnt_ff != 8'h00);
endmodule
`default_nettype wire

// ===== hw/hmch_top.sv
// The APB slave port and the placing of the registers were left to the implementer.
`default_nettype none
// Summary of operation
// RULE_01: host needs ready and monitoring before autosave
// RULE_02: autosave state kept in nonvolatile store
// RULE_03: sector count zero disables autosave
// RULE_04: sector count f1 enables autosave
// RULE_05: other nonzero autosave values also retained
// RULE_06: saving on power events stays allowed
// RULE_07: unsupported autosave aborts at once
// RULE_08: background routine keeps busy low, ready high
// RULE_09: new command answered within two seconds
// RULE_10: opcode b0 feature d8 is enable
// RULE_11: host loads signature 4f and c2
// RULE_12: bad feature or signature aborts enable
// RULE_13: abort sets error bit two
// RULE_14: success gives clean ready status
// RULE_15: fault flag on fault, error on errors; the fault flag is set only in aborted completion status
// RULE_16: nothing monitored before enable, ready only
// RULE_17: monitoring state kept in nonvolatile store
// RULE_18: repeat enable changes nothing
// RULE_19: opcode b0 feature d4 is off-line
// RULE_20: sector number picks the routine
// RULE_21: captive pass returns 4f and c2
// RULE_22: device select reflects selected drive
// RULE_23: decode subcommands 0,1,2,127,129,130
// RULE_24: captive fail aborts with f4 and 2c
// RULE_25: off-line completes before routine starts
// RULE_26: autosave and off-line need monitoring on
module hmch_top
  import hmch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic monitor_active_ff,
  output logic autosave_active_ff,
  output logic routine_active_ff
);
  ////////////////////////////////////////////////////////////////
  logic [7:0] feature_ff, sec_cnt_ff, sec_num_ff, sig_lo_ff, sig_hi_ff;
  logic [7:0] drv_sel_ff, status_ff, fault_ff, ctrl_ff, nv_rdata;
  logic [7:0] autosave_code_ff, routine_ff;
  logic [1:0] load_ff;
  logic nv_we, tmr_start, tmr_stop, tmr_busy, tmr_done;
  logic [1:0] nv_waddr, nv_raddr;
  logic [7:0] nv_wdata, tmr_len;
  logic wr_en, rd_en, cmd_wr;
  hmch_state_t state_ff;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  // no command is taken while a captive test holds the bus busy
  assign cmd_wr = wr_en && paddr == ADDR_OPCODE &&
    state_ff != HMCH_CAPTIVE;
  ////////////////////////////////////////////////////////////////
  // apb answers in the access cycle, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > ADDR_STATE;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      unique case (paddr)
        ADDR_SECCNT: prdata <= {24'h0, sec_cnt_ff};
        ADDR_SECNUM: prdata <= {24'h0, sec_num_ff};
        ADDR_SIGLO: prdata <= {24'h0, sig_lo_ff};
        ADDR_SIGHI: prdata <= {24'h0, sig_hi_ff};
        ADDR_DRVSEL: prdata <= {24'h0, drv_sel_ff};
        ADDR_FEATURE: prdata <= {24'h0, fault_ff};
        ADDR_OPCODE: prdata <= {24'h0, status_ff};
        ADDR_CTRL: prdata <= {24'h0, ctrl_ff};
        ADDR_STATE: prdata <= {21'h0, routine_active_ff,
          autosave_active_ff, monitor_active_ff, autosave_code_ff};
        default: prdata <= 32'h0;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // task-file inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feature_ff <= RST_BYTE;
      sec_cnt_ff <= RST_BYTE;
      sec_num_ff <= RST_BYTE;
      drv_sel_ff <= RST_BYTE;
      ctrl_ff <= 8'h04;
    end else if (wr_en && state_ff != HMCH_CAPTIVE) begin
      unique case (paddr)
        ADDR_FEATURE: feature_ff <= pwdata[7:0];
        ADDR_SECCNT: sec_cnt_ff <= pwdata[7:0];
        ADDR_SECNUM: sec_num_ff <= pwdata[7:0];
        ADDR_DRVSEL: drv_sel_ff <= pwdata[7:0];
        ADDR_CTRL: ctrl_ff <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // settings reload after reset from nv store, two reads
  assign nv_raddr = load_ff[0] ? NV_AS : NV_MON;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_ff <= 2'd0;
    end else if (load_ff != 2'd3) begin
      load_ff <= load_ff + 2'd1;
    end
  end
  ////////////////////////////////////////////////////////////////
  logic sig_ok, need_mon, do_as, do_en, do_off, bad, captive, nv_as;
  assign sig_ok = sig_lo_ff == SIG_LO_KEY && sig_hi_ff == SIG_HI_KEY;
  assign captive = sec_num_ff == SUB_SHORT_CAP || sec_num_ff == SUB_EXT_CAP;
  assign do_as = feature_ff == FEAT_AUTOSAVE;
  assign do_en = feature_ff == FEAT_ENABLE;
  assign do_off = feature_ff == FEAT_OFFLINE;
  assign need_mon = do_as || do_off;
  // RULE_12 RULE_07 RULE_26 abort checks
  assign bad = pwdata[7:0] != OPC_HEALTH || !sig_ok ||
    !(do_as || do_en || do_off) || (need_mon && !monitor_active_ff) ||
    (do_as && !ctrl_ff[CTRL_SUPPORT_AS]) ||
    (do_off && !(captive || sec_num_ff <= SUB_EXT_OFF ||
      sec_num_ff == SUB_ABORT_OFF));
  assign nv_as = cmd_wr && !bad && do_as;
  ////////////////////////////////////////////////////////////////
  // RULE_02 RULE_17 RULE_05 settings to nv store
  always_comb begin
    nv_we = 1'b0;
    nv_waddr = NV_MON;
    nv_wdata = 8'h00;
    if (cmd_wr && !bad && do_en && !monitor_active_ff) begin
      nv_we = 1'b1;
      nv_wdata = 8'h01;
    end else if (nv_as) begin
      nv_we = 1'b1;
      nv_waddr = NV_AS;
      nv_wdata = sec_cnt_ff;
    end
  end
  hmch_nvstore u_nv (
    .pclk(pclk),
    .we(nv_we),
    .waddr(nv_waddr),
    .wdata(nv_wdata),
    .raddr(nv_raddr),
    .rdata(nv_rdata)
  );
  // RULE_16 RULE_18 monitoring enable, repeat is no-op
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_active_ff <= 1'b0;
    end else if (load_ff == 2'd1) begin
      monitor_active_ff <= nv_rdata[0];
    end else if (cmd_wr && !bad && do_en) begin
      monitor_active_ff <= 1'b1;
    end
  end
  // RULE_03 RULE_04 RULE_06 autosave code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      autosave_code_ff <= AUTOSAVE_OFF;
      autosave_active_ff <= 1'b0;
    end else if (load_ff == 2'd2) begin
      autosave_code_ff <= nv_rdata;
      autosave_active_ff <= nv_rdata == AUTOSAVE_ON;
    end else if (nv_as) begin
      autosave_code_ff <= sec_cnt_ff;
      autosave_active_ff <= sec_cnt_ff == AUTOSAVE_ON;
    end
  end
  ////////////////////////////////////////////////////////////////
  // RULE_20 RULE_23 RULE_25 routine launch after completion
  // captive choice from the latched routine, not the live register
  logic rtn_cap;
  assign rtn_cap = routine_ff == SUB_SHORT_CAP || routine_ff == SUB_EXT_CAP;
  assign tmr_len = rtn_cap ? 8'(CAPTIVE_CYC) : 8'(ROUTINE_CYC);
  // RULE_09 any new command stops the background routine
  assign tmr_stop = cmd_wr && state_ff == HMCH_IDLE;
  assign tmr_start = state_ff == HMCH_EXEC;
  hmch_timer u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(tmr_start),
    .len(tmr_len),
    .stop(tmr_stop),
    .busy(tmr_busy),
    .done(tmr_done)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= HMCH_IDLE;
      routine_ff <= 8'h00;
    end else begin
      unique case (state_ff)
        HMCH_IDLE: if (cmd_wr && !bad && do_off) begin
          routine_ff <= sec_num_ff;
          // both kinds pass through exec so the timer gets loaded
          state_ff <= HMCH_EXEC;
        end
        HMCH_EXEC: state_ff <= rtn_cap ? HMCH_CAPTIVE : HMCH_IDLE;
        HMCH_CAPTIVE: if (tmr_done) begin
          state_ff <= HMCH_IDLE;
        end
      endcase
    end
  end
  // RULE_08 background routine flag only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routine_active_ff <= 1'b0;
    end else begin
      routine_active_ff <= tmr_busy && state_ff == HMCH_IDLE &&
        routine_ff != SUB_ABORT_OFF;
    end
  end
  ////////////////////////////////////////////////////////////////
  // completion: status, error, signature
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= RST_STATUS;
      fault_ff <= RST_BYTE;
      sig_lo_ff <= RST_BYTE;
      sig_hi_ff <= RST_BYTE;
    end else if (state_ff == HMCH_CAPTIVE) begin
      if (tmr_done && ctrl_ff[CTRL_TEST_FAIL]) begin
        // RULE_24 captive fail
        sig_lo_ff <= SIG_LO_FAIL;
        sig_hi_ff <= SIG_HI_FAIL;
        fault_ff <= 8'h04;
        status_ff <= {1'b0, 1'b1, ctrl_ff[CTRL_FAULT], 4'h0, 1'b1};
      end else if (tmr_done) begin
        // RULE_21 captive pass
        sig_lo_ff <= SIG_LO_KEY;
        sig_hi_ff <= SIG_HI_KEY;
        status_ff <= RST_STATUS;
      end
    end else if (cmd_wr) begin
      if (bad) begin
        // RULE_13 RULE_15 abort report
        fault_ff <= 8'h04;
        status_ff <= {1'b0, 1'b1, ctrl_ff[CTRL_FAULT], 4'h0, 1'b1};
      end else if (do_off && captive) begin
        fault_ff <= 8'h00;
        status_ff <= 8'hc0;
      end else begin
        // RULE_14 clean completion
        fault_ff <= 8'h00;
        status_ff <= RST_STATUS;
      end
    end else if (wr_en && paddr == ADDR_SIGLO) begin
      sig_lo_ff <= pwdata[7:0];
    end else if (wr_en && paddr == ADDR_SIGHI) begin
      sig_hi_ff <= pwdata[7:0];
    end
  end
  // RULE_22 device select bit is held from host write
  ////////////////////////////////////////////////////////////////
  property p_abort_bit;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr && bad && state_ff == HMCH_IDLE |=>
        fault_ff[BIT_COMMAND_ABORTED_BIT] && status_ff[BIT_ERR] && !status_ff[BIT_BUSY];
  endproperty
  a_abort_bit: assert property (p_abort_bit) else $error("no abort"); // RULE_13
  property p_ok_status;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr && !bad && do_en && state_ff == HMCH_IDLE |=>
        status_ff == RST_STATUS && fault_ff == 8'h00;
  endproperty
  a_ok_status: assert property (p_ok_status) else $error("bad ok"); // RULE_14
  property p_bg_ready;
    @(posedge pclk) disable iff (!presetn)
      routine_active_ff |-> !status_ff[BIT_BUSY] && status_ff[BIT_DRIVE_READY_FLAG];
  endproperty
  a_bg_ready: assert property (p_bg_ready) else $error("bg busy"); // RULE_08
  property p_as_on;
    @(posedge pclk) disable iff (!presetn)
      nv_as && sec_cnt_ff == AUTOSAVE_ON |=> autosave_active_ff;
  endproperty
  a_as_on: assert property (p_as_on) else $error("as on"); // RULE_04
  property p_as_off;
    @(posedge pclk) disable iff (!presetn)
      nv_as && sec_cnt_ff == AUTOSAVE_OFF |=> !autosave_active_ff;
  endproperty
  a_as_off: assert property (p_as_off) else $error("as off"); // RULE_03
  property p_mon_gate;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr && need_mon && !monitor_active_ff |-> bad;
  endproperty
  a_mon_gate: assert property (p_mon_gate) else $error("no mon"); // RULE_26
  sequence s_cap_done;
    state_ff == HMCH_CAPTIVE && tmr_done && !ctrl_ff[CTRL_TEST_FAIL];
  endsequence
  property p_cap_pass;
    @(posedge pclk) disable iff (!presetn)
      s_cap_done |=> sig_lo_ff == SIG_LO_KEY && sig_hi_ff == SIG_HI_KEY;
  endproperty
  a_cap_pass: assert property (p_cap_pass) else $error("cap sig"); // RULE_21
  property p_cap_fail;
    @(posedge pclk) disable iff (!presetn)
      state_ff == HMCH_CAPTIVE && tmr_done && ctrl_ff[CTRL_TEST_FAIL] |=>
        sig_lo_ff == SIG_LO_FAIL && fault_ff[BIT_COMMAND_ABORTED_BIT];
  endproperty
  a_cap_fail: assert property (p_cap_fail) else $error("cap fail"); // RULE_24
  property p_offline_bg;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr && !bad && do_off && !captive && state_ff == HMCH_IDLE |=>
        status_ff == RST_STATUS ##1 tmr_start == 1'b0 ##1 tmr_busy;
  endproperty
  a_offline_bg: assert property (p_offline_bg) else $error("bg order"); // RULE_25
  // RULE_09 new command halts routine
  property p_bg_halt;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr && state_ff == HMCH_IDLE && !(do_off && !bad) |=> !tmr_busy;
  endproperty
  a_bg_halt: assert property (p_bg_halt) else $error("bg halt"); // RULE_09
  // RULE_15 error flag tracks error byte
  property p_err_flag;
    @(posedge pclk) disable iff (!presetn)
      status_ff[BIT_ERR] == (fault_ff != 8'h00);
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("err flag"); // RULE_15
  // RULE_18 repeat enable leaves settings
  property p_mon_repeat;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr && do_en && monitor_active_ff |=>
        $stable(autosave_code_ff) && monitor_active_ff;
  endproperty
  a_mon_repeat: assert property (p_mon_repeat) else $error("repeat"); // RULE_18
  // RULE_22 command keeps device select
  property p_dev_hold;
    @(posedge pclk) disable iff (!presetn)
      cmd_wr |=> $stable(drv_sel_ff);
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("dev sel"); // RULE_22
  // RULE_20 routine inputs frozen while captive
  property p_cap_refuse;
    @(posedge pclk) disable iff (!presetn)
      wr_en && state_ff == HMCH_CAPTIVE |=>
        $stable(sec_num_ff) && $stable(feature_ff);
  endproperty
  a_cap_refuse: assert property (p_cap_refuse) else $error("cap wr"); // RULE_20
endmodule
`default_nettype wire

// ===== tb/hmch_host_model.sv
`default_nettype none
// host adapter: loads the task file over apb, one transfer at a time
module hmch_host_model
  import hmch_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [11:0] paddr,
  output var logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////////////////
  // leading edge wait keeps back-to-back calls off the release step
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [7:0] d, output logic [31:0] q,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic err;
    xfer(1'b1, a, d, q, err);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // keys loaded before opcode
  task automatic cmd(input logic [7:0] f, input logic [7:0] cnt,
                     input logic [7:0] num, input logic [7:0] lo,
                     input logic [7:0] hi);
    wr(ADDR_FEATURE, f);
    wr(ADDR_SECCNT, cnt);
    wr(ADDR_SECNUM, num);
    wr(ADDR_SIGLO, lo);
    wr(ADDR_SIGHI, hi);
    wr(ADDR_OPCODE, OPC_HEALTH);
  endtask
endmodule
`default_nettype wire

// ===== tb/health_monitor_command_handler_tb_top.sv
`default_nettype none
module health_monitor_command_handler_tb_top
  import hmch_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic mon, asv, rtn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  always #2 pclk = ~pclk;
  hmch_top hmch_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .monitor_active_ff(mon), .autosave_active_ff(asv),
    .routine_active_ff(rtn));
  hmch_host_model hmch_host_model_i (.pclk(pclk), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [10:0] e,
                     input logic [10:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic rd(input logic [11:0] a);
    hmch_host_model_i.xfer(1'b0, a, 8'h00, q, err);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    hmch_host_model_i.wr(a, d);
  endtask
  task automatic cmd(input logic [7:0] f, input logic [7:0] cnt,
                     input logic [7:0] num);
    hmch_host_model_i.cmd(f, cnt, num, SIG_LO_KEY, SIG_HI_KEY);
  endtask
  // error byte is only defined on an aborted completion
  task automatic fin(input logic [7:0] st, input logic [7:0] er);
    rd(ADDR_OPCODE);
    cmp("status", {3'b000, st}, {3'b000, q[7:0]});
    if (st[BIT_ERR]) begin
      rd(ADDR_FEATURE);
      cmp("error", {3'b000, er}, {3'b000, q[7:0]});
    end
  endtask
  task automatic busy_wait();
    int n;
    n = 0;
    do begin
      rd(ADDR_OPCODE);
      n++;
    end while (q[BIT_BUSY] !== 1'b0 && n < 100);
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(ADDR_OPCODE);
    cmp("reset status", {3'b000, RST_STATUS}, {3'b000, q[7:0]});
    rd(12'h030);
    cmp("unmapped slverr", 11'h001, {10'h000, err});
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_DRVSEL, 8'h10);
    hmch_host_model_i.cmd(FEAT_ENABLE, 8'h00, 8'h00, 8'h00, SIG_HI_KEY);
    fin(8'h41, 8'h04);
    hmch_host_model_i.cmd(FEAT_ENABLE, 8'h00, 8'h00, SIG_LO_KEY, 8'h00);
    fin(8'h41, 8'h04);
    cmd(8'hd5, 8'h00, 8'h00);
    fin(8'h41, 8'h04);
    wr(ADDR_CTRL, 8'h05);
    hmch_host_model_i.cmd(FEAT_ENABLE, 8'h00, 8'h00, 8'h00, SIG_HI_KEY);
    fin(8'h61, 8'h04);
    wr(ADDR_CTRL, 8'h04);
    cmd(FEAT_ENABLE, 8'h00, 8'h00);
    fin(8'h40, 8'h00);
    cmp("monitor", 11'h001, {10'h000, mon});
    rd(ADDR_DRVSEL);
    cmp("drive select", 11'h010, {3'b000, q[7:0]});
    cmd(FEAT_AUTOSAVE, AUTOSAVE_ON, 8'h00);
    fin(8'h40, 8'h00);
    cmp("autosave on", 11'h001, {10'h000, asv});
    cmd(FEAT_AUTOSAVE, AUTOSAVE_OFF, 8'h00);
    rd(ADDR_STATE);
    cmp("state off", 11'h100, q[10:0]);
    cmd(FEAT_AUTOSAVE, 8'h35, 8'h00);
    cmd(FEAT_ENABLE, 8'h00, 8'h00);
    rd(ADDR_STATE);
    cmp("state other", 11'h135, q[10:0]);
    cmd(FEAT_AUTOSAVE, AUTOSAVE_ON, 8'h00);
    // power cycle: settings come back from the store
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(ADDR_STATE);
    cmp("state kept", 11'h3f1, q[10:0]);
    wr(ADDR_CTRL, 8'h00);
    cmd(FEAT_AUTOSAVE, AUTOSAVE_OFF, 8'h00);
    fin(8'h41, 8'h04);
    cmp("autosave held", 11'h001, {10'h000, asv});
    wr(ADDR_CTRL, 8'h04);
    for (int s = 0; s < 3; s++) begin
      cmd(FEAT_OFFLINE, 8'h00, 8'(s));
      fin(8'h40, 8'h00);
      cmp("routine", 11'h001, {10'h000, rtn});
      fin(8'h40, 8'h00);
    end
    cmd(FEAT_ENABLE, 8'h00, 8'h00);
    fin(8'h40, 8'h00);
    cmp("routine halt", 11'h000, {10'h000, rtn});
    cmd(FEAT_OFFLINE, 8'h00, SUB_SHORT_OFF);
    cmd(FEAT_OFFLINE, 8'h00, SUB_ABORT_OFF);
    fin(8'h40, 8'h00);
    cmp("routine stop", 11'h000, {10'h000, rtn});
    cmd(FEAT_OFFLINE, 8'h00, 8'h03);
    fin(8'h41, 8'h04);
    wr(ADDR_CTRL, 8'h06);
    cmd(FEAT_OFFLINE, 8'h00, SUB_EXT_CAP);
    busy_wait();
    fin(8'h41, 8'h04);
    rd(ADDR_SIGLO);
    cmp("fail low", {3'b000, SIG_LO_FAIL}, {3'b000, q[7:0]});
    rd(ADDR_SIGHI);
    cmp("fail high", {3'b000, SIG_HI_FAIL}, {3'b000, q[7:0]});
    wr(ADDR_CTRL, 8'h04);
    cmd(FEAT_OFFLINE, 8'h00, SUB_SHORT_CAP);
    busy_wait();
    fin(8'h40, 8'h00);
    rd(ADDR_SIGLO);
    cmp("pass low", {3'b000, SIG_LO_KEY}, {3'b000, q[7:0]});
    rd(ADDR_SIGHI);
    cmp("pass high", {3'b000, SIG_HI_KEY}, {3'b000, q[7:0]});
    report_and_stop();
  end
endmodule
`default_nettype wire
